/* design/shrp_pkg.sv */
// Package: field widths, frame layout and link timing for the serial register port
package shrp_pkg;

  localparam int INSTR_BITS = 5;
  localparam int ADDR_W     = 11;
  localparam int DATA_W     = 8;
  localparam int FRAME_BITS = INSTR_BITS + ADDR_W + DATA_W;
  localparam int ADDR_LAST  = INSTR_BITS + ADDR_W - 1;
  localparam int FRAME_LAST = FRAME_BITS - 1;
  localparam int CNT_W      = $clog2(FRAME_BITS + 1);
  localparam int DPOS_W     = $clog2(DATA_W);
  localparam int DEPTH      = 2 ** ADDR_W;

  // Top instruction bit gives the direction; the four lower bits are don't-care
  localparam logic                  INSTR_READ  = 1'b1;
  localparam logic                  INSTR_WRITE = 1'b0;
  localparam logic [INSTR_BITS-2:0] INSTR_LOW   = 4'h0;

  // Link timing, in ns, and the system clock period
  localparam int CLK_NS         = 4;
  localparam int SCLK_PERIOD_NS = 500;
  localparam int SCLK_HIGH_NS   = 205;
  localparam int CS_SETUP_NS    = 50;
  localparam int CS_HOLD_NS     = 100;
  localparam int CS_HIGH_NS     = 100;

  localparam int SCLK_HALF_NS = (SCLK_PERIOD_NS / 2 > SCLK_HIGH_NS) ?
                                SCLK_PERIOD_NS / 2 : SCLK_HIGH_NS;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int CS_SETUP_CYC  = (CS_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CS_HOLD_CYC   = (CS_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CS_HIGH_CYC   = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int PH_W          = 8;

  typedef enum logic [2:0] {
    HS_IDLE,
    HS_SETUP,
    HS_LOW,
    HS_HIGH,
    HS_HOLD,
    HS_GAP
  } shrp_hstate_t;

endpackage

/* design/shrp_if.sv */
// Interface: serial link between the host end and the device end
`timescale 1ns/1ps
`default_nettype none

interface shrp_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe_n;
  wire  sdo_line;

  // Released line reads low
  assign sdo_line = sdo_oe_n ? 1'b0 : sdo;

  modport device_mp (
    input  cs_n,
    input  sclk,
    input  sdi,
    output sdo,
    output sdo_oe_n
  );

  modport host_mp (
    output cs_n,
    output sclk,
    output sdi,
    input  sdo_line
  );
endinterface

`default_nettype wire

/* design/shrp_device.sv */
// Device end: link-clocked shifter, register store and event crossing to the system clock
`timescale 1ns/1ps
`default_nettype none

// Function
// [R1] Chip select low frames one complete access
// [R2] Five instruction bits taken on rising clock
// [R3] Instruction top bit: one reads, zero writes
// [R4] Eleven address bits follow and select register
// [R5] Read data shifted out on falling edges
// [R6] Write data follows address and is stored
// [R7] Eight data bits, MSB first, low bits ignored; the device stores and returns all eight data bits
module shrp_device
  import shrp_pkg::*;
(
  shrp_if.device_mp         lnk,
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  output var  logic         wr_valid_out,
  output var  logic [10:0]  wr_addr_out,
  output var  logic [7:0]   wr_data_out,
  output var  logic         rd_valid_out,
  output var  logic [10:0]  rd_addr_out,
  output var  logic         abort_out,
  output var  logic         frame_open_out
);

  // Link domain state
  logic                  link_rst;
  logic [CNT_W-1:0]      bit_cnt;
  logic                  is_read;
  logic [ADDR_W-1:0]     addr_sr;
  logic [DATA_W-1:0]     data_sr;
  logic [DATA_W-1:0]     rd_word;
  logic [DATA_W-1:0]     mem [DEPTH];
  logic                  wr_tog;
  logic                  rd_tog;
  logic                  done_tog;
  logic [ADDR_W-1:0]     ev_addr;
  logic [DATA_W-1:0]     ev_data;

  // System domain state
  logic [2:0]            wr_sync;
  logic [2:0]            rd_sync;
  logic [2:0]            done_sync;
  logic [2:0]            cs_sync;
  logic                  done_pend;

  // Chip select high ends the frame at once, whatever the clock does
  assign link_rst = rst_in | lnk.cs_n;  // see [R1]

  wire                   at_cmd_bit;
  wire                   in_addr;
  wire                   in_data;
  wire                   at_addr_last;
  wire                   at_data_last;
  wire                   frame_full;
  wire                   do_write;
  wire                   do_rd_ev;
  wire [ADDR_W-1:0]      next_addr;
  wire [DATA_W-1:0]      next_data;
  wire [CNT_W-1:0]       rd_pos;
  wire                   drive_sdo;

  assign at_cmd_bit   = bit_cnt == '0;
  assign in_addr      = bit_cnt >= CNT_W'(INSTR_BITS) && bit_cnt <= CNT_W'(ADDR_LAST);
  assign in_data      = bit_cnt > CNT_W'(ADDR_LAST) && bit_cnt < CNT_W'(FRAME_BITS);
  assign at_addr_last = bit_cnt == CNT_W'(ADDR_LAST);
  assign at_data_last = bit_cnt == CNT_W'(FRAME_LAST);
  assign frame_full   = bit_cnt == CNT_W'(FRAME_BITS);
  assign next_addr    = {addr_sr[ADDR_W-2:0], lnk.sdi};  // see [R7]
  assign next_data    = {data_sr[DATA_W-2:0], lnk.sdi};  // see [R7]
  assign do_write     = at_data_last && !is_read;        // see [R6]
  assign do_rd_ev     = at_addr_last && is_read;
  assign rd_pos       = CNT_W'(FRAME_LAST) - bit_cnt;
  assign drive_sdo    = is_read && in_data;              // see [R5]

  // Frame shifter; bits beyond the frame are ignored
  always_ff @(posedge lnk.sclk or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt <= '0;
      is_read <= 1'b0;
      addr_sr <= '0;
      data_sr <= '0;
    end else begin
      if (!frame_full) begin
        bit_cnt <= bit_cnt + 1'b1;  // see [R2]
      end
      if (at_cmd_bit) begin
        is_read <= lnk.sdi == INSTR_READ;  // see [R3]
      end
      if (in_addr) begin
        addr_sr <= next_addr;  // see [R4]
      end
      if (in_data && !is_read) begin
        data_sr <= next_data;  // see [R6]
      end
    end
  end

  // Register store
  always_ff @(posedge lnk.sclk) begin
    if (do_write) begin
      mem[addr_sr] <= next_data;  // see [R6]
    end
    if (at_addr_last) begin
      rd_word <= mem[next_addr];  // see [R4]
    end
  end

  // Events for the system side; address and data stay put until the next event
  always_ff @(posedge lnk.sclk or posedge rst_in) begin
    if (rst_in) begin
      wr_tog   <= 1'b0;
      rd_tog   <= 1'b0;
      done_tog <= 1'b0;
      ev_addr  <= '0;
      ev_data  <= '0;
    end else begin
      if (do_write) begin
        wr_tog  <= ~wr_tog;
        ev_addr <= addr_sr;
        ev_data <= next_data;
      end
      if (do_rd_ev) begin
        rd_tog  <= ~rd_tog;
        ev_addr <= next_addr;
      end
      if (at_data_last) begin
        done_tog <= ~done_tog;  // see [R1]
      end
    end
  end

  // Read data changes on falling edges, MSB first, line released otherwise
  always_ff @(negedge lnk.sclk or posedge link_rst) begin
    if (link_rst) begin
      lnk.sdo      <= 1'b0;
      lnk.sdo_oe_n <= 1'b1;
    end else begin
      lnk.sdo      <= drive_sdo ? rd_word[rd_pos[DPOS_W-1:0]] : 1'b0;  // see [R5]
      lnk.sdo_oe_n <= !drive_sdo;
    end
  end

  // System side: toggle and level synchronisers
  wire wr_seen;
  wire rd_seen;
  wire done_seen;
  wire frame_close;

  assign wr_seen     = wr_sync[2] ^ wr_sync[1];
  assign rd_seen     = rd_sync[2] ^ rd_sync[1];
  assign done_seen   = done_sync[2] ^ done_sync[1];
  assign frame_close = cs_sync[1] && !cs_sync[2];

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_sync   <= '0;
      rd_sync   <= '0;
      done_sync <= '0;
      cs_sync   <= 3'h7;
    end else begin
      wr_sync   <= {wr_sync[1:0], wr_tog};
      rd_sync   <= {rd_sync[1:0], rd_tog};
      done_sync <= {done_sync[1:0], done_tog};
      cs_sync   <= {cs_sync[1:0], lnk.cs_n};
    end
  end

  // A frame that closes without a completed transfer is reported as aborted
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_pend      <= 1'b0;
      abort_out      <= 1'b0;
      frame_open_out <= 1'b0;
    end else begin
      frame_open_out <= !cs_sync[1];
      abort_out      <= frame_close && !(done_pend || done_seen);  // see [R1]
      if (frame_close) begin
        done_pend <= 1'b0;
      end else if (done_seen) begin
        done_pend <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_valid_out <= 1'b0;
      wr_addr_out  <= '0;
      wr_data_out  <= '0;
      rd_valid_out <= 1'b0;
      rd_addr_out  <= '0;
    end else begin
      wr_valid_out <= wr_seen;
      rd_valid_out <= rd_seen;
      if (wr_seen) begin
        wr_addr_out <= ev_addr;
        wr_data_out <= ev_data;
      end
      if (rd_seen) begin
        rd_addr_out <= ev_addr;
      end
    end
  end

endmodule

`default_nettype wire

/* design/shrp_host.sv */
// Host end: frames accesses, makes the serial clock by division and collects read data
`timescale 1ns/1ps
`default_nettype none

module shrp_host
  import shrp_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC,
  parameter int CSS_CYC  = CS_SETUP_CYC,
  parameter int CSD_CYC  = CS_HOLD_CYC,
  parameter int CSH_CYC  = CS_HIGH_CYC
)
(
  shrp_if.host_mp           lnk,
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire logic         req_valid_in,
  input  wire logic         req_read_in,
  input  wire logic [10:0]  req_addr_in,
  input  wire logic [7:0]   req_data_in,
  output var  logic         req_ready_out,
  output var  logic         rsp_valid_out,
  output var  logic [7:0]   rsp_data_out
);

  shrp_hstate_t            state;
  logic [PH_W-1:0]         ph_cnt;
  logic [CNT_W-1:0]        bit_cnt;
  logic [FRAME_BITS-1:0]   tx_sr;
  logic [DATA_W-1:0]       rx_sr;
  logic                    rd_op;
  logic                    sdo_s1;
  logic                    sdo_s2;

  wire                     ph_done;
  wire [PH_W-1:0]          ph_dec;
  wire                     last_bit;
  wire                     cmd_bit;
  wire [DATA_W-1:0]        tx_data;
  wire [FRAME_BITS-1:0]    next_frame;

  assign ph_done    = ph_cnt <= PH_W'(1);
  assign ph_dec     = ph_cnt - 1'b1;
  assign last_bit   = bit_cnt == CNT_W'(FRAME_BITS);
  assign cmd_bit    = req_read_in ? INSTR_READ : INSTR_WRITE;  // see [R3]
  assign tx_data    = req_read_in ? '0 : req_data_in;
  // Instruction, address, data, all MSB first
  assign next_frame = {cmd_bit, INSTR_LOW, req_addr_in, tx_data};  // see [R7]

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sdo_s1 <= 1'b0;
      sdo_s2 <= 1'b0;
    end else begin
      sdo_s1 <= lnk.sdo_line;
      sdo_s2 <= sdo_s1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state         <= HS_IDLE;
      ph_cnt        <= '0;
      bit_cnt       <= '0;
      tx_sr         <= '0;
      rx_sr         <= '0;
      rd_op         <= 1'b0;
      lnk.cs_n      <= 1'b1;
      lnk.sclk      <= 1'b0;
      lnk.sdi       <= 1'b0;
      req_ready_out <= 1'b1;
      rsp_valid_out <= 1'b0;
      rsp_data_out  <= '0;
    end else begin
      rsp_valid_out <= 1'b0;
      case (state)
        HS_IDLE: begin
          if (req_valid_in) begin
            tx_sr         <= next_frame;
            lnk.sdi       <= next_frame[FRAME_LAST];
            lnk.cs_n      <= 1'b0;  // see [R1]
            rd_op         <= req_read_in;
            bit_cnt       <= '0;
            ph_cnt        <= PH_W'(CSS_CYC);
            req_ready_out <= 1'b0;
            state         <= HS_SETUP;
          end
        end
        HS_SETUP: begin
          ph_cnt <= ph_done ? PH_W'(HALF_CYC) : ph_dec;
          if (ph_done) begin
            state <= HS_LOW;
          end
        end
        HS_LOW: begin
          ph_cnt <= ph_done ? PH_W'(HALF_CYC) : ph_dec;
          if (ph_done) begin
            lnk.sclk <= 1'b1;  // see [R2]
            rx_sr    <= {rx_sr[DATA_W-2:0], sdo_s2};
            bit_cnt  <= bit_cnt + 1'b1;
            state    <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (!ph_done) begin
            ph_cnt <= ph_dec;
          end else if (last_bit) begin
            lnk.sclk <= 1'b0;
            ph_cnt   <= PH_W'(CSD_CYC);
            state    <= HS_HOLD;
          end else begin
            lnk.sclk <= 1'b0;
            tx_sr    <= {tx_sr[FRAME_LAST-1:0], 1'b0};
            lnk.sdi  <= tx_sr[FRAME_LAST-1];  // see [R4] [R6]
            ph_cnt   <= PH_W'(HALF_CYC);
            state    <= HS_LOW;
          end
        end
        HS_HOLD: begin
          ph_cnt <= ph_done ? PH_W'(CSH_CYC) : ph_dec;
          if (ph_done) begin
            lnk.cs_n      <= 1'b1;  // see [R1]
            lnk.sdi       <= 1'b0;
            rsp_valid_out <= 1'b1;
            rsp_data_out  <= rd_op ? rx_sr : '0;
            state         <= HS_GAP;
          end
        end
        HS_GAP: begin
          ph_cnt <= ph_dec;
          if (ph_done) begin
            req_ready_out <= 1'b1;
            state         <= HS_IDLE;
          end
        end
        default: begin
          state <= HS_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* test/shrp_link_checker.sv */
// Checker: framing and timing on the link between host and device ends
`timescale 1ns/1ps
`default_nettype none

module shrp_link_checker (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic sdi_in,
  input wire logic sdo_in,
  input wire logic sdo_oe_n_in
);
  logic [4:0] rise_cnt;
  logic       sclk_d;
  logic       dir;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  // Counts serial clock rises in the open frame and keeps its direction bit
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_d   <= 1'b0;
      rise_cnt <= 5'h00;
      dir      <= 1'b0;
    end else begin
      sclk_d   <= sclk_in;
      rise_cnt <= cs_n_in ? 5'h00 : rise_cnt + 5'(sclk_in & ~sclk_d);
      if (sclk_in & ~sclk_d & (rise_cnt == 5'h00)) begin
        dir <= sdi_in;
      end
    end
  end

  sclk_idle_a: assert property (cs_n_in |-> !sclk_in)
    else $error("sclk high outside a frame");
  sdo_release_a: assert property (cs_n_in |-> sdo_oe_n_in)
    else $error("sdo driven outside a frame");
  sdo_steady_a: assert property (sclk_in && $past(sclk_in) |-> $stable(sdo_in))
    else $error("sdo moved while sclk high");
  sdi_steady_a: assert property (sclk_in && $past(sclk_in) |-> $stable(sdi_in))
    else $error("sdi moved while sclk high");
  frame_bits_a: assert property ($rose(cs_n_in) |-> rise_cnt == 5'h18)
    else $error("frame closed without 24 clock rises");
  read_start_a: assert property ($fell(sdo_oe_n_in) |-> dir && rise_cnt == 5'h10)
    else $error("sdo drive began at wrong point");
  read_span_a: assert property (!sdo_oe_n_in |-> rise_cnt >= 5'h10)
    else $error("sdo driven during address phase");
  read_end_a: assert property ($rose(sdo_oe_n_in) |-> rise_cnt == 5'h18)
    else $error("sdo released early");
  sclk_start_a: assert property ($fell(cs_n_in) |-> ##[1:300] sclk_in)
    else $error("no clock after frame opened");

  cover property ($fell(sdo_oe_n_in));
  cover property ($rose(cs_n_in) && !dir);
  cover property ($rose(cs_n_in) && dir);
endmodule

`default_nettype wire

/* test/test_serial_host_register_port.sv */
// Testbench: host and device on one link, a second device driven by hand
`timescale 1ns/1ps
`default_nettype none

module test_serial_host_register_port;
  import shrp_pkg::*;

  logic        sys_clk_in   = 1'b0;
  logic        rst_in       = 1'b0;
  logic        req_valid_in = 1'b0;
  logic        req_read_in  = 1'b0;
  logic [10:0] req_addr_in  = 11'h000;
  logic [7:0]  req_data_in  = 8'h00;
  logic        req_ready_out;
  logic        rsp_valid_out;
  logic [7:0]  rsp_data_out;
  logic        wv [2];
  logic [10:0] wa [2];
  logic [7:0]  wd [2];
  logic        rv [2];
  logic [10:0] ra [2];
  logic        ab [2];
  logic        fo [2];
  int          wn [2] = '{0, 0};
  int          rn [2] = '{0, 0};
  int          an [2] = '{0, 0};
  int          fail_count = 0;
  int          checks_done = 0;

  shrp_if lnk ();
  shrp_if lnk2 ();

  always #2 sys_clk_in = ~sys_clk_in;

  shrp_host #(.HALF_CYC(4), .CSS_CYC(1), .CSD_CYC(1), .CSH_CYC(2)) shrp_host_inst (
    .lnk(lnk), .sys_clk_in(sys_clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
    .req_read_in(req_read_in), .req_addr_in(req_addr_in), .req_data_in(req_data_in),
    .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out));
  shrp_device shrp_device_inst (
    .lnk(lnk), .sys_clk_in(sys_clk_in), .rst_in(rst_in), .wr_valid_out(wv[0]),
    .wr_addr_out(wa[0]), .wr_data_out(wd[0]), .rd_valid_out(rv[0]), .rd_addr_out(ra[0]),
    .abort_out(ab[0]), .frame_open_out(fo[0]));
  shrp_device shrp_device_inst_b (
    .lnk(lnk2), .sys_clk_in(sys_clk_in), .rst_in(rst_in), .wr_valid_out(wv[1]),
    .wr_addr_out(wa[1]), .wr_data_out(wd[1]), .rd_valid_out(rv[1]), .rd_addr_out(ra[1]),
    .abort_out(ab[1]), .frame_open_out(fo[1]));
  shrp_link_checker shrp_link_checker_inst (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .cs_n_in(lnk.cs_n), .sclk_in(lnk.sclk),
    .sdi_in(lnk.sdi), .sdo_in(lnk.sdo), .sdo_oe_n_in(lnk.sdo_oe_n));

  // Counts one-cycle event pulses of both devices
  always @(negedge sys_clk_in) begin
    for (int i = 0; i < 2; i++) begin
      wn[i] += int'(wv[i] === 1'b1);
      rn[i] += int'(rv[i] === 1'b1);
      an[i] += int'(ab[i] === 1'b1);
    end
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic await(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1) begin
      @(negedge sys_clk_in);
      if (++n > 500) begin
        fail_count++;
        $display("Error %0t: wait ran out", $time);
        end_of_test();
      end
    end
  endtask

  task automatic xfer(input logic rd, input logic [10:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    await(req_ready_out);
    req_valid_in = 1'b1;
    req_read_in  = rd;
    req_addr_in  = a;
    req_data_in  = d;
    @(negedge sys_clk_in);
    req_valid_in = 1'b0;
    await(rsp_valid_out);
    q = rsp_data_out;
    repeat (8) @(negedge sys_clk_in);
    chk(11'(fo[0]), 11'h000);
  endtask

  // Drives n bits of a frame on the second link with a 32 ns clock
  task automatic frame2(input logic [23:0] bits, input int n, output logic [7:0] q);
    @(negedge sys_clk_in);
    #1.3;
    lnk2.cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      lnk2.sdi = bits[23-i];
      #16;
      if (i > 15) q = {q[6:0], lnk2.sdo_line};
      lnk2.sclk = 1'b1;
      #16;
      lnk2.sclk = 1'b0;
    end
    chk(11'(fo[1]), 11'h001);
    #16;
    lnk2.cs_n = 1'b1;
    lnk2.sdi  = ~lnk2.sdi;
    repeat (8) @(negedge sys_clk_in);
    chk(11'(fo[1]), 11'h000);
  endtask

  task automatic t_write_read;
    logic [10:0] ad [3] = '{11'h7ff, 11'h000, 11'h2aa};
    logic [7:0]  dt [3] = '{8'ha5, 8'h5a, 8'h81};
    logic [7:0]  q;
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, ad[i], dt[i], q);
      chk(11'(wn[0]), 11'(i + 1));
      chk(wa[0], ad[i]);
      chk(11'(wd[0]), 11'(dt[i]));
      chk(11'(q), 11'h000);
    end
    for (int i = 2; i >= 0; i--) begin
      xfer(1'b1, ad[i], 8'h00, q);
      chk(11'(q), 11'(dt[i]));
      chk(ra[0], ad[i]);
    end
    chk(11'(wn[0]), 11'h003);
    chk(11'(rn[0]), 11'h003);
    chk(11'(an[0]), 11'h000);
  endtask

  task automatic t_abort;
    logic [7:0] q;
    frame2({1'b0, 4'hf, 11'h155, 8'h3c}, 20, q);
    chk(11'(an[1]), 11'h001);
    chk(11'(wn[1]), 11'h000);
    frame2({1'b0, 4'hf, 11'h155, 8'h3c}, 24, q);
    chk(11'(wn[1]), 11'h001);
    chk(wa[1], 11'h155);
    chk(11'(wd[1]), 11'h03c);
    chk(11'(an[1]), 11'h001);
    frame2({1'b1, 4'h5, 11'h155, 8'h00}, 24, q);
    chk(11'(q), 11'h03c);
    chk(ra[1], 11'h155);
    chk(11'(wn[1]), 11'h001);
  endtask

  // Reset rises after time zero so that every link-clocked reset sees an edge
  initial begin
    #1;
    rst_in    = 1'b1;
    lnk2.cs_n = 1'b1;
    lnk2.sclk = 1'b0;
    lnk2.sdi  = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    rst_in = 1'b0;
    t_write_read();
    t_abort();
    end_of_test();
  end
endmodule

`default_nettype wire
